/* File: logic/blx_exec.v */
// Executes the bit-transfer and byte memory-load instruction group.
// Assumes an asynchronous-read register file and a memory whose read
// data is valid one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "blx_defs.vh"

// Contract
// - Extract form: source bit into destination bit 0
// - Insert form: bit 0 into selected bit
// - Second byte: register, bit index, direction
// - Other bits, source and flags untouched
// - Even pair program, odd pair data memory
// - Indirect load/store via pair, ten cycles
// - Short index byte offset, twelve cycles
// - Long index two bytes, fourteen cycles
// - Long index pair 0000/0001 means direct address
// - Source, flags, non-auto pair unchanged
// - Program memory writes only if writable
// - Load then decrement pair, ten cycles
// - Decrement form follows pair parity space
// - Load then increment pair
// - Increment form follows pair parity space
module blx_exec #(
    parameter PROG_WRITABLE = 1
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // Instruction
    input  wire        instr_valid,
    output wire        instr_ready,
    input  wire [7:0]  op_code,
    input  wire [7:0]  op_byte2,
    input  wire [7:0]  op_byte3,
    input  wire [7:0]  op_byte4,
    input  wire [7:0]  work_base,
    output reg         instr_done,
    output reg         instr_refused,
    // Register file
    output reg  [7:0]  reg_addr,
    output reg         reg_rd,
    output reg         reg_wr,
    output reg  [7:0]  reg_wdata,
    input  wire [7:0]  reg_rdata,
    // Memory
    output reg  [15:0] mem_addr,
    output reg         mem_prog_sel,
    output reg         mem_rd,
    output reg         mem_wr,
    output reg  [7:0]  mem_wdata,
    input  wire [7:0]  mem_rdata
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [10:0] S_IDLE = 11'h001;
    localparam [10:0] S_HI   = 11'h002;
    localparam [10:0] S_LO   = 11'h004;
    localparam [10:0] S_WRK  = 11'h008;
    localparam [10:0] S_SET  = 11'h010;
    localparam [10:0] S_MEM  = 11'h020;
    localparam [10:0] S_MWT  = 11'h040;
    localparam [10:0] S_BWR  = 11'h080;
    localparam [10:0] S_WLO  = 11'h100;
    localparam [10:0] S_WHI  = 11'h200;
    localparam [10:0] S_HOLD = 11'h400;

    localparam [1:0] T_HI  = 2'h0;
    localparam [1:0] T_LO  = 2'h1;
    localparam [1:0] T_WRK = 2'h2;

    reg  [10:0] st_q;
    reg  [10:0] st_d;
    reg  [7:0]  op_q;
    reg  [7:0]  b2_q;
    reg  [7:0]  b3_q;
    reg  [7:0]  b4_q;
    reg  [3:0]  bank_q;
    reg  [3:0]  cnt_q;
    reg  [7:0]  hi_q;
    reg  [7:0]  lo_q;
    reg  [7:0]  wrk_q;
    reg  [1:0]  tgt_q;
    reg         mrv_q;
    reg         refuse_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire        is_bit   = (op_q == `BLX_OP_BIT);
    wire        is_xs    = (op_q == `BLX_OP_LD_XS) || (op_q == `BLX_OP_ST_XS);
    wire        is_xl    = (op_q == `BLX_OP_LD_XL) || (op_q == `BLX_OP_ST_XL);
    wire        is_store = (op_q == `BLX_OP_ST_IND) || (op_q == `BLX_OP_ST_XS) ||
                           (op_q == `BLX_OP_ST_XL);
    wire        is_dec   = (op_q == `BLX_OP_LD_DEC);
    wire        is_inc   = (op_q == `BLX_OP_LD_INC);
    wire [3:0]  wrk_num  = b2_q[`BLX_F_WRK_HI:`BLX_F_WRK_LO];
    wire [2:0]  bit_idx  = b2_q[`BLX_F_BIT_HI:`BLX_F_BIT_LO];
    wire        bit_ins  = b2_q[`BLX_F_DIR];
    wire [3:0]  pair_num = b2_q[3:0];
    wire        direct   = is_xl && (pair_num[3:1] == `BLX_PAIR_DIRECT);
    // Even pair selects program memory, odd selects data memory
    wire        prog_sp  = ~pair_num[0];
    wire        rom_blk  = (PROG_WRITABLE == 0) && is_store && prog_sp;

    wire [7:0]  wrk_addr = {bank_q, wrk_num};
    wire [7:0]  phi_addr = {bank_q, pair_num[3:1], 1'b0};
    wire [7:0]  plo_addr = {bank_q, pair_num[3:1], 1'b1};

    function [7:0] bit_merge;
        input [7:0] base;
        input [2:0] pos;
        input       val;
        integer     i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                bit_merge[i] = (i == pos) ? val : base[i];
            end
        end
    endfunction

    // Extract keeps bits 7:1 of the working register
    wire [7:0]  ext_val  = {wrk_q[7:1], hi_q[bit_idx]};
    wire [7:0]  ins_val  = bit_merge(hi_q, bit_idx, wrk_q[0]);

    // ----------------------------------------
    // Address arithmetic
    // ----------------------------------------
    wire [15:0] offset   = is_xs ? {8'h00, b3_q} : {b4_q, b3_q};
    wire [15:0] eff_addr;
    wire [15:0] pair_inc;
    wire [15:0] pair_dec;
    wire [15:0] pair_new = is_dec ? pair_dec : pair_inc;

    blx_addr_gen u_addr (
        .pair_val   ({hi_q, lo_q}),
        .offset     (offset),
        .use_offset (is_xs | is_xl),
        .direct     (direct),
        .eff_addr   (eff_addr),
        .pair_inc   (pair_inc),
        .pair_dec   (pair_dec)
    );

    // ----------------------------------------
    // Cycle budget
    // ----------------------------------------
    reg  [3:0]  cyc;
    reg         legal;

    always @* begin
        legal = 1'b1;
        case (op_code)
            `BLX_OP_BIT:                   cyc = `BLX_CYC_BIT;
            `BLX_OP_LD_IND, `BLX_OP_ST_IND: cyc = `BLX_CYC_IND;
            `BLX_OP_LD_XS, `BLX_OP_ST_XS:   cyc = `BLX_CYC_XS;
            `BLX_OP_LD_XL, `BLX_OP_ST_XL:   cyc = `BLX_CYC_XL;
            `BLX_OP_LD_DEC, `BLX_OP_LD_INC: cyc = `BLX_CYC_AUTO;
            default: begin
                cyc   = 4'h1;
                legal = 1'b0;
            end
        endcase
    end

    reg  [3:0]  cyc_q;

    assign instr_ready = (st_q == S_IDLE);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        st_d = st_q;
        case (st_q)
            S_IDLE: begin
                if (instr_valid) begin
                    st_d = legal ? S_HI : S_IDLE;
                end
            end
            S_HI: begin
                if (is_bit) begin
                    st_d = S_WRK;
                end else if (direct) begin
                    st_d = is_store ? S_WRK : S_SET;
                end else begin
                    st_d = S_LO;
                end
            end
            S_LO:    st_d = is_store ? S_WRK : S_SET;
            S_WRK:   st_d = S_SET;
            S_SET:   st_d = is_bit ? S_BWR : S_MEM;
            S_MEM:   st_d = is_store ? S_HOLD : S_MWT;
            S_MWT: begin
                if (mrv_q) begin
                    st_d = (is_dec | is_inc) ? S_WLO : S_HOLD;
                end
            end
            S_BWR:   st_d = S_HOLD;
            S_WLO:   st_d = S_WHI;
            S_WHI:   st_d = S_HOLD;
            S_HOLD: begin
                if (cnt_q == cyc_q - 4'h1) begin
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    // ----------------------------------------
    // Sequencer and datapath
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            st_q          <= S_IDLE;
            op_q          <= 8'h00;
            b2_q          <= 8'h00;
            b3_q          <= 8'h00;
            b4_q          <= 8'h00;
            bank_q        <= 4'h0;
            cyc_q         <= 4'h1;
            cnt_q         <= 4'h0;
            hi_q          <= 8'h00;
            lo_q          <= 8'h00;
            wrk_q         <= 8'h00;
            tgt_q         <= T_HI;
            mrv_q         <= 1'b0;
            refuse_q      <= 1'b0;
            instr_done    <= 1'b0;
            instr_refused <= 1'b0;
            reg_addr      <= 8'h00;
            reg_rd        <= 1'b0;
            reg_wr        <= 1'b0;
            reg_wdata     <= 8'h00;
            mem_addr      <= 16'h0000;
            mem_prog_sel  <= 1'b0;
            mem_rd        <= 1'b0;
            mem_wr        <= 1'b0;
            mem_wdata     <= 8'h00;
        end else begin
            st_q          <= st_d;
            reg_rd        <= 1'b0;
            reg_wr        <= 1'b0;
            mem_rd        <= 1'b0;
            mem_wr        <= 1'b0;
            instr_done    <= 1'b0;
            instr_refused <= 1'b0;
            mrv_q         <= mem_rd;
            cnt_q         <= (st_q == S_IDLE) ? 4'h1 : cnt_q + 4'h1;

            // Asynchronous register file: data is valid with the strobe
            if (reg_rd) begin
                case (tgt_q)
                    T_HI:    hi_q  <= reg_rdata;
                    T_LO:    lo_q  <= reg_rdata;
                    default: wrk_q <= reg_rdata;
                endcase
            end

            case (st_q)
                S_IDLE: begin
                    if (instr_valid) begin
                        op_q     <= op_code;
                        b2_q     <= op_byte2;
                        b3_q     <= op_byte3;
                        b4_q     <= op_byte4;
                        bank_q   <= work_base[7:4];
                        cyc_q    <= cyc;
                        refuse_q <= ~legal;
                        // Unknown opcodes end at once; the counter cannot stop at one
                        instr_done    <= ~legal;
                        instr_refused <= ~legal;
                    end
                end
                S_HI: begin
                    // Bit form: general register; pair forms: pair high
                    if (is_bit) begin
                        reg_rd   <= 1'b1;
                        reg_addr <= b3_q;
                        tgt_q    <= T_HI;
                    end else if (!direct) begin
                        reg_rd   <= 1'b1;
                        reg_addr <= phi_addr;
                        tgt_q    <= T_HI;
                    end
                end
                S_LO: begin
                    reg_rd   <= 1'b1;
                    reg_addr <= plo_addr;
                    tgt_q    <= T_LO;
                end
                S_WRK: begin
                    reg_rd   <= 1'b1;
                    reg_addr <= wrk_addr;
                    tgt_q    <= T_WRK;
                end
                S_MEM: begin
                    mem_addr     <= eff_addr;
                    mem_prog_sel <= prog_sp;
                    if (is_store) begin
                        mem_wdata <= wrk_q;
                        // Mask-ROM parts drop program writes
                        mem_wr    <= ~rom_blk;
                        refuse_q  <= rom_blk;
                    end else begin
                        mem_rd    <= 1'b1;
                    end
                end
                S_MWT: begin
                    if (mrv_q) begin
                        reg_wr    <= 1'b1;
                        reg_addr  <= wrk_addr;
                        reg_wdata <= mem_rdata;
                    end
                end
                S_BWR: begin
                    reg_wr <= 1'b1;
                    if (bit_ins) begin
                        reg_addr  <= b3_q;
                        reg_wdata <= ins_val;
                    end else begin
                        reg_addr  <= wrk_addr;
                        reg_wdata <= ext_val;
                    end
                end
                // Pair written back only after the load; plain forms never write it
                S_WLO: begin
                    reg_wr    <= 1'b1;
                    reg_addr  <= plo_addr;
                    reg_wdata <= pair_new[7:0];
                end
                S_WHI: begin
                    reg_wr    <= 1'b1;
                    reg_addr  <= phi_addr;
                    reg_wdata <= pair_new[15:8];
                end
                S_HOLD: begin
                    if (cnt_q == cyc_q - 4'h1) begin
                        instr_done    <= 1'b1;
                        instr_refused <= refuse_q;
                    end
                end
                default: begin
                    tgt_q <= T_HI;
                end
            endcase
        end
    end

endmodule // blx_exec

`default_nettype wire

/* File: logic/blx_defs.vh */
// Constants for the bit-transfer and memory-load execution block.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef BLX_DEFS_VH
`define BLX_DEFS_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define BLX_OP_BIT      8'h47
`define BLX_OP_LD_IND   8'hc3
`define BLX_OP_ST_IND   8'hd3
`define BLX_OP_LD_XS    8'he7
`define BLX_OP_ST_XS    8'hf7
`define BLX_OP_LD_XL    8'ha7
`define BLX_OP_ST_XL    8'hb7
`define BLX_OP_LD_DEC   8'he2
`define BLX_OP_LD_INC   8'he3

// ----------------------------------------
// Cycle counts, acceptance to done
// ----------------------------------------
`define BLX_CYC_BIT     4'h6
`define BLX_CYC_IND     4'ha
`define BLX_CYC_XS      4'hc
`define BLX_CYC_XL      4'he
`define BLX_CYC_AUTO    4'ha

// ----------------------------------------
// Field positions of the second byte
// ----------------------------------------
`define BLX_F_WRK_HI    7
`define BLX_F_WRK_LO    4
`define BLX_F_BIT_HI    3
`define BLX_F_BIT_LO    1
`define BLX_F_DIR       0
`define BLX_PAIR_DIRECT 3'h0

`endif

/* File: logic/blx_addr_gen.v */
// Effective memory address and pair step values.
// Purely combinational; the caller supplies latched operands.
`timescale 1ns/10ps
`default_nettype none

module blx_addr_gen (
    // Operands
    input  wire [15:0] pair_val,
    input  wire [15:0] offset,
    input  wire        use_offset,
    input  wire        direct,
    // Results
    output wire [15:0] eff_addr,
    output wire [15:0] pair_inc,
    output wire [15:0] pair_dec
);

    wire [15:0] idx_sum;

    // Sum drops the carry out, so it wraps at 64 KiB
    assign idx_sum  = pair_val + (use_offset ? offset : 16'h0000);
    assign eff_addr = direct ? offset : idx_sum;
    // Full 16-bit step carries between low and high registers
    assign pair_inc = pair_val + 16'h0001;
    assign pair_dec = pair_val - 16'h0001;

endmodule // blx_addr_gen

`default_nettype wire

/* File: tb/blx_chk.sv */
// Checker for the execution block: cycle counts and memory space.
// Sees only the block's ports; attached by bind.
`timescale 1ns/10ps
`default_nettype none

module blx_chk #(
    parameter PROG_WRITABLE = 1
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Instruction and memory
    input wire logic       instr_valid,
    input wire logic       instr_ready,
    input wire logic [7:0] op_code,
    input wire logic [7:0] op_byte2,
    input wire logic       instr_done,
    input wire logic       instr_refused,
    input wire logic       mem_prog_sel,
    input wire logic       mem_rd,
    input wire logic       mem_wr
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire        take = instr_valid && instr_ready;
    logic [7:0] pair_q;
    // Pair field is only on the inputs at acceptance
    always @(posedge clock) begin
        if (take) begin
            pair_q <= op_byte2;
        end
    end
    // ----
    // Assertions
    // ----
    a_bit_done_six: assert property (
        take && op_code == 8'h47 |-> ##6 instr_done) else $error("bit done late");
    a_bit_busy_span: assert property (
        take && op_code == 8'h47 |=> !instr_ready [*5] ##1 instr_ready)
        else $error("bit busy span wrong");
    a_ind_done_ten: assert property (
        take && (op_code == 8'hc3 || op_code == 8'hd3)
        |=> !instr_done [*8] ##1 !instr_done ##1 instr_done) else $error("indirect count");
    a_auto_done_ten: assert property (
        take && (op_code == 8'he2 || op_code == 8'he3) |-> ##10 instr_done)
        else $error("auto step count");
    a_short_done_twelve: assert property (
        take && (op_code == 8'he7 || op_code == 8'hf7) |-> ##12 instr_done)
        else $error("short index count");
    a_long_done_fourteen: assert property (
        take && (op_code == 8'ha7 || op_code == 8'hb7) |-> ##14 instr_done)
        else $error("long index count");
    a_space_by_parity: assert property (
        mem_rd || mem_wr |-> mem_prog_sel == !pair_q[0]) else $error("wrong space");
    a_rom_store_blocked: assert property (
        mem_wr && mem_prog_sel |-> PROG_WRITABLE != 0) else $error("store into rom");
    a_refuse_with_done: assert property (
        instr_refused |-> instr_done) else $error("refuse without done");
    c_long_store: cover property (take && op_code == 8'hb7);
    c_data_write: cover property (mem_wr && !mem_prog_sel);
    c_refused: cover property (instr_refused);
endmodule // blx_chk

bind blx_exec blx_chk #(.PROG_WRITABLE(PROG_WRITABLE)) blx_chk_i (
    .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .op_code(op_code), .op_byte2(op_byte2), .instr_done(instr_done),
    .instr_refused(instr_refused), .mem_prog_sel(mem_prog_sel), .mem_rd(mem_rd),
    .mem_wr(mem_wr));

`default_nettype wire

/* File: tb/blx_mem.sv */
// Register file and both memories facing the execution block.
// Assumes async register reads and memory data one cycle after mem_rd.
`timescale 1ns/10ps
`default_nettype none

module blx_mem (
    // Clock
    input wire logic        clock,
    // Register file
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    output logic     [7:0]  reg_rdata,
    // Memory
    input wire logic [15:0] mem_addr,
    input wire logic        mem_prog_sel,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    output logic     [7:0]  mem_rdata
);
    logic [7:0] rf [0:255];
    logic [7:0] prog [0:65535];
    logic [7:0] data [0:65535];
    // Idle lines show the inverse so a stale byte never passes
    assign reg_rdata = reg_rd ? rf[reg_addr] : ~rf[reg_addr];
    initial mem_rdata = 8'h00;
    always @(posedge clock) begin
        if (reg_wr) begin
            rf[reg_addr] <= reg_wdata;
        end
        if (mem_wr && mem_prog_sel) begin
            prog[mem_addr] <= mem_wdata;
        end
        if (mem_wr && !mem_prog_sel) begin
            data[mem_addr] <= mem_wdata;
        end
        mem_rdata <= !mem_rd ? ~mem_rdata : mem_prog_sel ? prog[mem_addr] : data[mem_addr];
    end
endmodule // blx_mem

`default_nettype wire

/* File: tb/bit_and_memory_load_exec_bench.sv */
// Self-checking bench for the execution block.
// Assumes blx_mem as register file and memories; checker comes by bind.
`timescale 1ns/10ps
`default_nettype none

module bit_and_memory_load_exec_bench;
    logic        clock, rst, instr_valid;
    logic [7:0]  op_code, op_byte2, op_byte3, op_byte4, work_base;
    wire         instr_ready, instr_done, instr_refused, reg_rd, reg_wr;
    wire         mem_prog_sel, mem_rd, mem_wr;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata, mem_wdata, mem_rdata;
    wire  [15:0] mem_addr;
    integer      bad_count, checked, i;

    blx_exec blx_exec_i (.clock(clock), .rst(rst), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .op_code(op_code), .op_byte2(op_byte2),
        .op_byte3(op_byte3), .op_byte4(op_byte4), .work_base(work_base),
        .instr_done(instr_done), .instr_refused(instr_refused), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_prog_sel(mem_prog_sel), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    blx_mem blx_mem_i (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_prog_sel(mem_prog_sel), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    always #50 clock = ~clock;

    function automatic logic [7:0] pat(input logic pg, input logic [15:0] a);
        pat = a[7:0] ^ a[15:8] ^ (pg ? 8'h5a : 8'ha5);
    endfunction

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task end_of_test;
        begin
            if (bad_count == 0 && checked > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask

    // Entered at a falling edge; leaves at the falling edge showing done,
    // so the next call is taken back to back with it
    task go(input logic [7:0] op, b2, b3, b4, input logic [15:0] n);
        integer k;
        begin
            chk(instr_ready, 16'h1);
            instr_valid = 1'b1;
            op_code = op;
            op_byte2 = b2;
            op_byte3 = b3;
            op_byte4 = b4;
            @(negedge clock);
            instr_valid = 1'b0;
            k = 1;
            while (instr_done !== 1'b1 && k < 40) begin
                @(negedge clock);
                k = k + 1;
            end
            chk(k[15:0], n);
            chk(instr_refused, {15'h0, n == 16'h1});
        end
    endtask

    task xfer(input logic [7:0] op, b2, b3, b4, input logic [15:0] n,
              input logic st, pg, input logic [15:0] pr, ad, epr);
        begin
            {blx_mem_i.rf[8'h12], blx_mem_i.rf[8'h13]} = pr;
            blx_mem_i.rf[8'h10] = 8'h3c ^ ad[7:0];
            go(op, b2, b3, b4, n);
            if (st) begin
                chk(pg ? blx_mem_i.prog[ad] : blx_mem_i.data[ad], 8'h3c ^ ad[7:0]);
                chk(pg ? blx_mem_i.data[ad] : blx_mem_i.prog[ad], pat(!pg, ad));
                chk(blx_mem_i.rf[8'h10], 8'h3c ^ ad[7:0]);
            end else begin
                chk(blx_mem_i.rf[8'h10], pat(pg, ad));
            end
            chk({blx_mem_i.rf[8'h12], blx_mem_i.rf[8'h13]}, epr);
        end
    endtask

    task s_bit;
        begin
            blx_mem_i.rf[8'h10] = 8'h06;
            blx_mem_i.rf[8'h00] = 8'h05;
            go(8'h47, 8'h04, 8'h00, 8'h00, 16'd6);
            chk(blx_mem_i.rf[8'h10], 8'h07);
            chk(blx_mem_i.rf[8'h00], 8'h05);
            go(8'h47, 8'h01, 8'h00, 8'h00, 16'd6);
            chk(blx_mem_i.rf[8'h00], 8'h05);
            blx_mem_i.rf[8'h13] = 8'hfe;
            go(8'h47, 8'h31, 8'h00, 8'h00, 16'd6);
            chk(blx_mem_i.rf[8'h00], 8'h04);
            blx_mem_i.rf[8'h07] = 8'h7f;
            go(8'h47, 8'h3e, 8'h07, 8'h00, 16'd6);
            chk(blx_mem_i.rf[8'h13], 8'hfe);
            chk(blx_mem_i.rf[8'h07], 8'h7f);
        end
    endtask

    task s_plain;
        begin
            xfer(8'hc3, 8'h02, 8'h00, 8'h00, 16'd10, 0, 1, 16'h0104, 16'h0104, 16'h0104);
            xfer(8'hc3, 8'h03, 8'h00, 8'h00, 16'd10, 0, 0, 16'h0104, 16'h0104, 16'h0104);
            xfer(8'hd3, 8'h02, 8'h00, 8'h00, 16'd10, 1, 1, 16'h0204, 16'h0204, 16'h0204);
            xfer(8'hd3, 8'h03, 8'h00, 8'h00, 16'd10, 1, 0, 16'h0304, 16'h0304, 16'h0304);
            xfer(8'he7, 8'h02, 8'h01, 8'h00, 16'd12, 0, 1, 16'h0104, 16'h0105, 16'h0104);
            xfer(8'hf7, 8'h03, 8'h20, 8'h00, 16'd12, 1, 0, 16'hfff0, 16'h0010, 16'hfff0);
        end
    endtask

    task s_long;
        begin
            xfer(8'ha7, 8'h02, 8'h00, 8'h10, 16'd14, 0, 1, 16'h0104, 16'h1104, 16'h0104);
            xfer(8'hb7, 8'h03, 8'h00, 8'h10, 16'd14, 1, 0, 16'h0104, 16'h1104, 16'h0104);
            xfer(8'ha7, 8'h00, 8'h06, 8'h11, 16'd14, 0, 1, 16'h4444, 16'h1106, 16'h4444);
            xfer(8'hb7, 8'h01, 8'h05, 8'h11, 16'd14, 1, 0, 16'h4444, 16'h1105, 16'h4444);
            xfer(8'hb7, 8'h00, 8'h07, 8'h11, 16'd14, 1, 1, 16'h4444, 16'h1107, 16'h4444);
        end
    endtask

    task s_auto;
        begin
            xfer(8'he2, 8'h02, 8'h00, 8'h00, 16'd10, 0, 1, 16'h1000, 16'h1000, 16'h0fff);
            xfer(8'he2, 8'h03, 8'h00, 8'h00, 16'd10, 0, 0, 16'h1033, 16'h1033, 16'h1032);
            xfer(8'he3, 8'h02, 8'h00, 8'h00, 16'd10, 0, 1, 16'h00ff, 16'h00ff, 16'h0100);
            xfer(8'he3, 8'h03, 8'h00, 8'h00, 16'd10, 0, 0, 16'hffff, 16'hffff, 16'h0000);
        end
    endtask

    // Unknown opcode goes last: its done lands on the edge that drops valid
    task s_illegal;
        begin
            go(8'hff, 8'h02, 8'h00, 8'h00, 16'd1);
        end
    endtask

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        instr_valid = 1'b0;
        {op_code, op_byte2, op_byte3, op_byte4} = 32'h0;
        work_base = 8'h10;
        bad_count = 0;
        checked = 0;
        for (i = 0; i < 65536; i = i + 1) begin
            blx_mem_i.prog[i] = pat(1'b1, i[15:0]);
            blx_mem_i.data[i] = pat(1'b0, i[15:0]);
        end
        repeat (16) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        s_bit;
        s_plain;
        s_long;
        s_auto;
        s_illegal;
        end_of_test;
    end

    initial begin
        #2000000;
        bad_count = bad_count + 1;
        end_of_test;
    end
endmodule // bit_and_memory_load_exec_bench

`default_nettype wire
